// [gbf_framer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gbf_consts.svh"

module gbf_framer #(
  // Cycles per broadcast period; shorten in simulation
  parameter int unsigned PERIOD_CYC = `GBF_PERIOD_MS * `GBF_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] src_addr,
  input wire logic not_auto_ready,
  input wire logic auto_state_fault,
  input wire logic [15:0] avg_ll_volt,
  input wire logic [15:0] avg_ln_volt,
  input wire logic [15:0] avg_freq,
  input wire logic [15:0] avg_curr,
  input wire logic [15:0] pha_freq,
  input wire logic [15:0] pha_curr,
  input wire logic [31:0] pha_real_pwr,
  input wire logic [31:0] pha_app_pwr,
  input wire logic [31:0] pha_react_pwr,
  input wire logic [15:0] phb_ll_volt,
  input wire logic [15:0] phb_ln_volt,
  input wire logic [15:0] phb_freq,
  input wire logic [15:0] phb_curr,
  input wire logic [31:0] phb_real_pwr,
  input wire logic [31:0] phb_app_pwr,
  input wire logic [31:0] phb_react_pwr,
  input wire logic [15:0] phc_freq,
  input wire logic frame_ready,
  output logic frame_valid,
  output logic [28:0] frame_id,
  output logic [63:0] frame_data
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Identifier from group codes; priority is a constant, never configured
  function automatic gbf_pkg::gbf_id_t fn_id(
    input logic [7:0] pf,
    input logic [7:0] ps,
    input logic [7:0] sa
  );
    gbf_pkg::gbf_id_t id;
    id = '0;
    id[`GBF_PRIO_POS+:3] = `GBF_PRIO;
    id[`GBF_PF_POS+:8] = pf;
    id[`GBF_PS_POS+:8] = ps;
    id[7:0] = sa;
    return id;
  endfunction : fn_id

  // Four 16-bit fields; least significant byte goes first on the wire
  function automatic gbf_pkg::gbf_data_t fn_pack16(
    input logic [15:0] f1,
    input logic [15:0] f2,
    input logic [15:0] f3,
    input logic [15:0] f4
  );
    return {f4[15:8], f4[7:0], f3[15:8], f3[7:0],
            f2[15:8], f2[7:0], f1[15:8], f1[7:0]};
  endfunction : fn_pack16

  // Two 32-bit fields, same byte order as the 16-bit case
  function automatic gbf_pkg::gbf_data_t fn_pack32(
    input logic [31:0] f1,
    input logic [31:0] f2
  );
    return {f2[31:24], f2[23:16], f2[15:8], f2[7:0],
            f1[31:24], f1[23:16], f1[15:8], f1[7:0]};
  endfunction : fn_pack32

  // Lowest pending slot wins the transmit queue
  function automatic gbf_pkg::gbf_idx_t fn_first(
    input logic [`GBF_NMSG-1:0] req
  );
    gbf_pkg::gbf_idx_t ix;
    ix = '0;
    for (int i = `GBF_NMSG - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        ix = 4'(i);
      end
    end
    return ix;
  endfunction : fn_first

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0] cnt_ff [`GBF_NMSG]; // Period counters, one per message
  logic [31:0] nxt_cnt [`GBF_NMSG];
  logic [`GBF_NMSG-1:0] pend_ff; // Frames waiting for the buffer
  logic [`GBF_NMSG-1:0] nxt_pend;
  logic [`GBF_NMSG-1:0] due; // Period elapsed this cycle
  logic [`GBF_NMSG-1:0] take; // One-hot slot taken this cycle
  logic push; // Frame enters the buffer
  gbf_pkg::gbf_idx_t sel; // Slot being packed
  gbf_pkg::gbf_auto_t auto_code; // Readiness code for byte 1
  gbf_pkg::gbf_id_t new_id; // Packed identifier
  gbf_pkg::gbf_data_t new_data; // Packed payload
  logic head_v_ff; // Output stage holds a frame
  logic nxt_head_v;
  gbf_pkg::gbf_id_t head_id_ff;
  gbf_pkg::gbf_id_t nxt_head_id;
  gbf_pkg::gbf_data_t head_data_ff;
  gbf_pkg::gbf_data_t nxt_head_data;
  logic skid_v_ff; // Second entry holds a frame
  logic nxt_skid_v;
  gbf_pkg::gbf_id_t skid_id_ff;
  gbf_pkg::gbf_id_t nxt_skid_id;
  gbf_pkg::gbf_data_t skid_data_ff;
  gbf_pkg::gbf_data_t nxt_skid_data;

  // ----------------------------------------
  // Readiness code
  // ----------------------------------------
  // Fault outranks not-ready; the code stays active for as long as
  // the input says the set cannot start and supply power
  always_comb
  begin
    auto_code = gbf_pkg::GBF_AUTO_READY;
    if (auto_state_fault)
    begin
      auto_code = gbf_pkg::GBF_AUTO_ERROR;
    end
    else if (not_auto_ready)
    begin
      auto_code = gbf_pkg::GBF_AUTO_NOT_READY;
    end
  end

  // ----------------------------------------
  // Payload packing
  // ----------------------------------------
  // Measurements are sampled in the cycle the frame enters the buffer
  always_comb
  begin
    new_id = fn_id(`GBF_PF_GC, `GBF_PS_GC, src_addr);
    new_data = {8{`GBF_FILL8}};
    case (sel)
      `GBF_IX_GC:
      begin
        // Neighbouring bits of byte 1 are unimplemented, so all ones
        new_data[`GBF_AUTO_LSB+1:`GBF_AUTO_LSB] = auto_code;
      end
      `GBF_IX_AVG:
      begin
        new_id = fn_id(`GBF_PF_AVG, `GBF_PS_AVG, src_addr);
        new_data = fn_pack16(avg_ll_volt, avg_ln_volt,
                             avg_freq, avg_curr);
      end
      `GBF_IX_PAB:
      begin
        new_id = fn_id(`GBF_PF_PAB, `GBF_PS_PAB, src_addr);
        new_data = fn_pack16(`GBF_FILL16, `GBF_FILL16,
                             pha_freq, pha_curr);
      end
      `GBF_IX_PAP:
      begin
        new_id = fn_id(`GBF_PF_PAP, `GBF_PS_PAP, src_addr);
        new_data = fn_pack32(pha_real_pwr, pha_app_pwr);
      end
      `GBF_IX_PAR:
      begin
        new_id = fn_id(`GBF_PF_PAR, `GBF_PS_PAR, src_addr);
        new_data = fn_pack32(pha_react_pwr, `GBF_FILL32);
      end
      `GBF_IX_PBB:
      begin
        new_id = fn_id(`GBF_PF_PBB, `GBF_PS_PBB, src_addr);
        new_data = fn_pack16(phb_ll_volt, phb_ln_volt,
                             phb_freq, phb_curr);
      end
      `GBF_IX_PBP:
      begin
        new_id = fn_id(`GBF_PF_PBP, `GBF_PS_PBP, src_addr);
        new_data = fn_pack32(phb_real_pwr, phb_app_pwr);
      end
      `GBF_IX_PBR:
      begin
        new_id = fn_id(`GBF_PF_PBR, `GBF_PS_PBR, src_addr);
        new_data = fn_pack32(phb_react_pwr, `GBF_FILL32);
      end
      `GBF_IX_PCB:
      begin
        new_id = fn_id(`GBF_PF_PCB, `GBF_PS_PCB, src_addr);
        new_data = fn_pack16(`GBF_FILL16, `GBF_FILL16,
                             phc_freq, `GBF_FILL16);
      end
      default:
      begin
        // Unused slot numbers keep the defaults; push never selects them
      end
    endcase
  end

  // ----------------------------------------
  // Period scheduler
  // ----------------------------------------
  // Own counter per slot: frames due together queue, none is stretched
  always_comb
  begin
    sel = fn_first(pend_ff);
    push = (|pend_ff) && !skid_v_ff;
    take = '0;
    if (push)
    begin
      take[sel] = 1'b1;
    end
    for (int i = 0; i < `GBF_NMSG; i++)
    begin
      due[i] = (cnt_ff[i] == PERIOD_CYC - 32'h1);
      nxt_cnt[i] = due[i] ? `GBF_CNT_RST : cnt_ff[i] + 32'h1;
    end
    // A fresh period wins over the take, so no interval is lost
    nxt_pend = (pend_ff & ~take) | due;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_ff <= `GBF_PEND_RST;
      for (int i = 0; i < `GBF_NMSG; i++)
      begin
        cnt_ff[i] <= `GBF_CNT_RST;
      end
    end
    else if (clk_en)
    begin
      pend_ff <= nxt_pend;
      for (int i = 0; i < `GBF_NMSG; i++)
      begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  // Second entry catches a push while the head stalls; when full it blocks push while the period counters keep running
  always_comb
  begin
    nxt_head_v = head_v_ff;
    nxt_head_id = head_id_ff;
    nxt_head_data = head_data_ff;
    nxt_skid_v = skid_v_ff;
    nxt_skid_id = skid_id_ff;
    nxt_skid_data = skid_data_ff;
    if (!head_v_ff || frame_ready)
    begin
      if (skid_v_ff)
      begin
        // Older frame moves up first to keep order
        nxt_head_v = 1'b1;
        nxt_head_id = skid_id_ff;
        nxt_head_data = skid_data_ff;
        nxt_skid_v = 1'b0;
      end
      else
      begin
        nxt_head_v = push;
        if (push)
        begin
          nxt_head_id = new_id;
          nxt_head_data = new_data;
        end
      end
    end
    else if (push)
    begin
      // Head stalled: park the new frame
      nxt_skid_v = 1'b1;
      nxt_skid_id = new_id;
      nxt_skid_data = new_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      head_v_ff <= 1'b0;
      head_id_ff <= '0;
      head_data_ff <= '0;
      skid_v_ff <= 1'b0;
      skid_id_ff <= '0;
      skid_data_ff <= '0;
    end
    else if (clk_en)
    begin
      head_v_ff <= nxt_head_v;
      head_id_ff <= nxt_head_id;
      head_data_ff <= nxt_head_data;
      skid_v_ff <= nxt_skid_v;
      skid_id_ff <= nxt_skid_id;
      skid_data_ff <= nxt_skid_data;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All straight from the head registers
  assign frame_valid = head_v_ff;
  assign frame_id = head_id_ff;
  assign frame_data = head_data_ff;
endmodule : gbf_framer
`default_nettype wire

// [gbf_consts.svh]
`ifndef GBF_CONSTS_SVH
`define GBF_CONSTS_SVH
// ----------------------------------------
// Frame identifier layout
// ----------------------------------------
`define GBF_PRIO 3'h3
`define GBF_PRIO_POS 26
`define GBF_PF_POS 16
`define GBF_PS_POS 8
// ----------------------------------------
// Message slots, lowest index sent first
// ----------------------------------------
`define GBF_NMSG 9
`define GBF_IX_GC 4'h0
`define GBF_IX_AVG 4'h1
`define GBF_IX_PAB 4'h2
`define GBF_IX_PAP 4'h3
`define GBF_IX_PAR 4'h4
`define GBF_IX_PBB 4'h5
`define GBF_IX_PBP 4'h6
`define GBF_IX_PBR 4'h7
`define GBF_IX_PCB 4'h8
// ----------------------------------------
// Group codes per slot
// ----------------------------------------
`define GBF_PF_GC 8'hfd
`define GBF_PS_GC 8'h93
`define GBF_PF_AVG 8'hfe
`define GBF_PS_AVG 8'h06
`define GBF_PF_PAB 8'hfe
`define GBF_PS_PAB 8'h03
`define GBF_PF_PAP 8'hfe
`define GBF_PS_PAP 8'h02
`define GBF_PF_PAR 8'hfe
`define GBF_PS_PAR 8'h00
`define GBF_PF_PBB 8'hfe
`define GBF_PS_PBB 8'h00
`define GBF_PF_PBP 8'hfd
`define GBF_PS_PBP 8'hff
`define GBF_PF_PBR 8'hfd
`define GBF_PS_PBR 8'hfe
`define GBF_PF_PCB 8'hfd
`define GBF_PS_PCB 8'hfd
// ----------------------------------------
// Field positions and fill values
// ----------------------------------------
`define GBF_AUTO_LSB 3
`define GBF_FILL8 8'hff
`define GBF_FILL16 16'hffff
`define GBF_FILL32 32'hffffffff
// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define GBF_PERIOD_MS 100
`define GBF_CLK_KHZ 200000
`define GBF_CNT_RST 32'h0
`define GBF_PEND_RST 9'h0
`endif

// [gbf_pkg.sv]
`default_nettype none
package gbf_pkg;
  // Code of the automatic-start readiness field
  typedef enum logic [1:0] {
    GBF_AUTO_READY = 2'h0,
    GBF_AUTO_NOT_READY = 2'h1,
    GBF_AUTO_ERROR = 2'h2,
    GBF_AUTO_NA = 2'h3
  } gbf_auto_t;
  // Message slot number
  typedef logic [3:0] gbf_idx_t;
  // Eight payload bytes, byte 1 in bits 7:0
  typedef logic [63:0] gbf_data_t;
  // Extended 29-bit identifier
  typedef logic [28:0] gbf_id_t;
endpackage : gbf_pkg
`default_nettype wire

// [gbf_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Frame link checker
// ----
module gbf_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic frame_ready,
  input wire logic frame_valid,
  input wire logic [28:0] frame_id,
  input wire logic [63:0] frame_data
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Frame leaves at this edge
  sequence s_take;
    frame_valid && frame_ready && clk_en;
  endsequence
  // Readiness frame on offer
  sequence s_gc;
    frame_valid && frame_id[23:8] == 16'hfd93;
  endsequence
  chk_hold_frame:
    assert property (frame_valid && !(frame_ready && clk_en) |=> frame_valid
      && $stable(frame_id) && $stable(frame_data)) else $error("frame moved");
  chk_prio_fixed:
    assert property (frame_valid |-> frame_id[28:24] == 5'h0c) else $error("bad priority");
  chk_ready_field:
    assert property (s_gc |-> frame_data[63:5] == '1 && frame_data[2:0] == 3'h7
      && frame_data[4:3] != 2'h3) else $error("bad readiness frame");
  chk_react_fill:
    assert property (frame_valid && frame_id[23:8] == 16'hfdfe |-> frame_data[63:32] == '1)
      else $error("bad reactive fill");
  chk_phc_fill:
    assert property (frame_valid && frame_id[23:8] == 16'hfdfd |-> frame_data[63:48] == '1
      && frame_data[31:0] == '1) else $error("bad phase C fill");
  chk_next_avg:
    assert property (s_take ##0 s_gc |=> frame_valid && frame_id[23:8] == 16'hfe06)
      else $error("average frame late");
  chk_freeze_idle:
    assert property (!clk_en |=> $stable(frame_valid) && $stable(frame_data))
      else $error("moved while frozen");
  chk_quiet_start:
    assert property ($rose(reset_n) |-> !frame_valid ##1 !frame_valid) else $error("early frame");
endmodule : gbf_monitor
bind gbf_framer gbf_monitor i_mon (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .clk_en(clk_en),
  .frame_ready(frame_ready),
  .frame_valid(frame_valid),
  .frame_id(frame_id),
  .frame_data(frame_data)
);
`default_nettype wire

// [gbf_can_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Receiving node: takes frames, may stall
// ----
module gbf_can_sink (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pace,
  output logic frame_ready
);
  logic [15:0] lfsr_ff; // Stall pattern source
  // Slow pace drops ready half the time, so the buffer fills up
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      lfsr_ff <= 16'hace1;
      frame_ready <= 1'b0;
    end
    else
    begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      frame_ready <= !pace || lfsr_ff[0];
    end
endmodule : gbf_can_sink
`default_nettype wire

// [gbf_framer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Random bursts against a stalling sink
// ----
module gbf_framer_bench;
  localparam int unsigned PER = 64; // Short period keeps the run brief
  localparam int NEN = 10 * PER + 50; // Ten bursts, next one not yet due
  localparam logic [15:0] GRP [0:8] = '{16'hfd93, 16'hfe06, 16'hfe03, 16'hfe02,
    16'hfe00, 16'hfe00, 16'hfdff, 16'hfdfe, 16'hfdfd};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic pace;
  logic not_auto_ready;
  logic auto_state_fault;
  logic [7:0] src_addr;
  logic [15:0] h [0:10]; // Sixteen-bit quantities
  logic [31:0] p [0:5]; // Power quantities
  logic frame_ready;
  logic frame_valid;
  logic [28:0] frame_id;
  logic [63:0] frame_data;
  logic [31:0] rng = 32'hcd7a9d40;
  int slot = 0;
  int nb = 0;
  int en_cnt = 0;
  int takes = 0;
  int mismatches = 0;
  int compares = 0;
  // 200 MHz clock, half period each way
  always #2.5 ref_clk = ~ref_clk;
  gbf_framer #(.PERIOD_CYC(PER)) i_dut (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .src_addr(src_addr),
    .not_auto_ready(not_auto_ready),
    .auto_state_fault(auto_state_fault),
    .avg_ll_volt(h[0]),
    .avg_ln_volt(h[1]),
    .avg_freq(h[2]),
    .avg_curr(h[3]),
    .pha_freq(h[4]),
    .pha_curr(h[5]),
    .pha_real_pwr(p[0]),
    .pha_app_pwr(p[1]),
    .pha_react_pwr(p[2]),
    .phb_ll_volt(h[6]),
    .phb_ln_volt(h[7]),
    .phb_freq(h[8]),
    .phb_curr(h[9]),
    .phb_real_pwr(p[3]),
    .phb_app_pwr(p[4]),
    .phb_react_pwr(p[5]),
    .phc_freq(h[10]),
    .frame_ready(frame_ready),
    .frame_valid(frame_valid),
    .frame_id(frame_id),
    .frame_data(frame_data)
  );
  gbf_can_sink i_sink (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pace(pace),
    .frame_ready(frame_ready)
  );
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [28:0] exp_id(input int s);
    return {3'h3, 2'h0, GRP[s], src_addr};
  endfunction : exp_id
  // Payload per slot, low byte of each field first
  function automatic logic [63:0] exp_data(input int s);
    logic [1:0] c;
    c = auto_state_fault ? 2'h2 : (not_auto_ready ? 2'h1 : 2'h0);
    case (s)
      0: return {56'hffffffffffffff, 3'h7, c, 3'h7};
      1: return {h[3], h[2], h[1], h[0]};
      2: return {h[5], h[4], 32'hffffffff};
      3: return {p[1], p[0]};
      4: return {32'hffffffff, p[2]};
      5: return {h[9], h[8], h[7], h[6]};
      6: return {p[4], p[3]};
      7: return {32'hffffffff, p[5]};
      default: return {16'hffff, h[10], 32'hffffffff};
    endcase
  endfunction : exp_data
  // Identifier of a frame taken by the sink
  task automatic cmp_id(input string nm, input logic [28:0] e, input logic [28:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_id
  // Payload of a frame taken by the sink
  task automatic cmp_data(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_data
  // Counts kept over the whole run
  task automatic cmp_count(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_count
  // New inputs after a burst; bursts 2 and 3 use all-zero and all-one values
  task automatic shuffle();
    logic [31:0] v;
    for (int i = 0; i < 17; i++)
    begin
      rng = xs(rng);
      v = (nb == 2) ? 32'h0 : (nb == 3) ? 32'hffffffff : rng;
      if (i < 11)
        h[i] <= v[15:0];
      else
        p[i - 11] <= v;
    end
    rng = xs(rng);
    src_addr <= rng[7:0];
    {auto_state_fault, not_auto_ready} <= 2'(nb);
    pace <= nb[2];
  endtask : shuffle
  task automatic end_sim();
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Drives clk_en and scores every frame that the sink takes
  always @(posedge ref_clk)
  begin
    rng = xs(rng);
    clk_en <= |rng[2:0];
    if (reset_n && clk_en)
      en_cnt <= en_cnt + 1;
    if (reset_n && clk_en && frame_valid && frame_ready)
    begin
      cmp_id("frame_id", exp_id(slot), frame_id);
      cmp_data("frame_data", exp_data(slot), frame_data);
      takes <= takes + 1;
      slot = (slot == 8) ? 0 : slot + 1;
      if (slot == 0)
      begin
        nb = nb + 1;
        shuffle();
      end
    end
  end
  // Reset, then run for NEN enabled edges (ten periods plus 50), at most 4000 cycles
  initial
  begin
    shuffle();
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4000 && en_cnt < NEN; i++)
      @(posedge ref_clk);
    cmp_count("enabled_edges", 32'(NEN), 32'(en_cnt));
    cmp_count("frames_taken", 32'd90, 32'(takes));
    end_sim();
  end
endmodule : gbf_framer_bench
`default_nettype wire
